/* File: hw/ted_cfg.svh */
/*
 Constants for the transient event detector: register offsets, field
 positions, reset values and debounce timing.
 Assumes a 125 MHz system clock and inclusion by bare name.
*/
`ifndef TED_CFG_SVH
`define TED_CFG_SVH

// ==========================================================
// Register offsets
`define TED_ADDR_FFMT_COUNT   8'h18
`define TED_ADDR_TR_CFG       8'h1d
`define TED_ADDR_TR_SRC       8'h1e
`define TED_ADDR_TR_THS       8'h1f
`define TED_ADDR_TR_COUNT     8'h20

// ==========================================================
// Reset values
`define TED_RST_BYTE          8'h00
`define TED_RST_CFG           5'h00
`define TED_RST_BIT           1'b0

// ==========================================================
// Field positions
`define TED_CFG_LATCH_BIT     4
`define TED_CFG_EN_HI         3
`define TED_CFG_EN_LO         1
`define TED_CFG_BYPASS_BIT    0
`define TED_THS_MODE_BIT      7
`define TED_THS_VAL_HI        6
`define TED_THS_VAL_LO        0
`define TED_SRC_EA_BIT        6
`define TED_SAMPLE_SIGN_BIT   11
`define TED_SAMPLE_THS_HI     11
`define TED_SAMPLE_THS_LO     4

// ==========================================================
// Threshold limits; 63 counts of 0.063 g is the 4 g ceiling
`define TED_THS_LOWNOISE_MAX  7'h3f

// ==========================================================
// Timing: base debounce step is 1.25 ms, clock period 8 ns
`define TED_BASE_STEP_NS      1250000
`define TED_CLK_PERIOD_NS     8

// Step multipliers of the 1.25 ms base step
`define TED_MULT_1            8'h01
`define TED_MULT_2            8'h02
`define TED_MULT_4            8'h04
`define TED_MULT_8            8'h08
`define TED_MULT_16           8'h10
`define TED_MULT_64           8'h40
`define TED_MULT_128          8'h80

// Data rate codes
`define TED_ODR_800           3'h0
`define TED_ODR_400           3'h1
`define TED_ODR_200           3'h2
`define TED_ODR_100           3'h3
`define TED_ODR_50            3'h4
`define TED_ODR_12P5          3'h5

`endif

/* File: hw/ted_pkg.sv */
/*
 Types shared by the transient event detector.
 Assumes ted_cfg.svh supplies the numeric constants.
*/
package ted_pkg;

	// ==========================================================
	// Oversampling modes
	typedef enum logic [1:0] {
		TED_MODE_NORMAL  = 2'h0,
		TED_MODE_LOWNOISE = 2'h1,
		TED_MODE_HIGH_RESOLUTION_MODE = 2'h2,
		TED_MODE_LOWPOWER = 2'h3
	} ted_mode_e;

	// ==========================================================
	// One sample per axis, two's complement, z in the top slot
	typedef struct packed {
		logic [11:0] z;
		logic [11:0] y;
		logic [11:0] x;
	} ted_axes_s;

	// Register access request from the serial interface
	typedef struct packed {
		logic [7:0] addr;
		logic       wrEn;
		logic       rdEn;
		logic [7:0] wrData;
	} ted_reg_req_s;

endpackage

/* File: hw/transient_event_detector.sv */
/*
 Transient (high-pass) event detector for three axes, with the debounce
 stage of the freefall/motion detector sharing the same step timer.
 Assumes the serial register interface presents one-cycle read and write
 strobes, samples arrive with a one-cycle valid, and the filter, the
 freefall/motion condition and interrupt routing live outside.
*/
`timescale 1ns/1ps
`include "ted_cfg.svh"

// Summary of operation
// [RULE1] Hold 8-bit freefall/motion count, reset zero
// [RULE2] Freefall/motion flag when counter reaches count
// [RULE3] Freefall/motion counter saturates at count
// [RULE4] Counter advances once per sample period; here once per shared debounce step of stepMult base steps, from rate and mode
// [RULE5] Transient step from rate and oversampling mode
// [RULE6] Config byte: latch, axis enables, bypass
// [RULE7] Enabled axis flags when change exceeds threshold
// [RULE8] Bypass selects unfiltered samples for comparison
// [RULE9] Source byte: EA bit 6, axis pairs
// [RULE10] EA set when enabled axis flag asserted
// [RULE11] Polarity zero positive, one negative
// [RULE12] Latched EA freezes other source bits
// [RULE13] Active EA: add axes, never clear
// [RULE14] Source read clears bits and interrupt
// [RULE15] 7-bit threshold, 0.063 g per count
// [RULE16] Low-noise limits threshold to 4 g
// [RULE17] Threshold bit 7 selects counter mode
// [RULE18] 8-bit transient count, reset zero
// [RULE19] Event flag; interrupt only when enabled
// [RULE20] Condition false: clear or decrement counter
// [RULE21] EA drives level interrupt until read
// [RULE22] Unlatched source follows live comparison; here it holds and adds axes until read once EA is set
module transient_event_detector #(
	parameter int unsigned BASE_STEP_CYCLES =
		`TED_BASE_STEP_NS / `TED_CLK_PERIOD_NS
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire ted_pkg::ted_reg_req_s regReq,
	output logic [7:0]                regRdData,
	input  wire logic                 sampleValid,
	input  wire ted_pkg::ted_axes_s   rawAxes,
	input  wire ted_pkg::ted_axes_s   filteredAxes,
	input  wire logic [2:0]           outputDataRate,
	input  wire ted_pkg::ted_mode_e   oversampleMode,
	input  wire logic                 lowNoiseEnable,
	input  wire logic                 transientIrqEnable,
	input  wire logic                 ffMotionCond,
	input  wire logic                 ffMotionCounterMode,
	output logic                      transientIrq,
	output logic                      ffMotionEvent,
	output logic                      stepTick
);
	import ted_pkg::*;

	// ==========================================================
	// Registers
	logic [4:0]  transientConfig_ff;
	logic [7:0]  transientThreshold_ff;
	logic [7:0]  transientCount_ff;
	logic [7:0]  ffMotionCount_ff;
	logic [2:0]  srcEvent_ff;
	logic [2:0]  srcPol_ff;
	logic        srcActive_ff;
	logic [7:0]  regRdData_ff;
	logic        transientIrq_ff;
	logic [7:0]  trDebounce_ff;
	logic [7:0]  ffDebounce_ff;
	logic        ffMotionEvent_ff;
	logic [2:0]  liveOver_ff;
	logic [2:0]  livePol_ff;
	logic [31:0] baseCnt_ff;
	logic [7:0]  multCnt_ff;
	logic        stepTick_ff;

	logic [7:0]  nxt_trDebounce;
	logic [7:0]  nxt_ffDebounce;
	logic [2:0]  nxt_srcEvent;
	logic [2:0]  nxt_srcPol;
	logic        nxt_srcActive;
	logic [7:0]  nxt_regRdData;

	logic        latchEnable;
	logic [2:0]  axisEnable;
	logic        filterBypass;
	logic        counterModeSelect;
	logic [6:0]  thresholdValue;
	logic [6:0]  effThreshold;
	logic [2:0][11:0] selAxes;
	logic [2:0]  axisOver;
	logic [2:0]  axisNeg;
	logic        trCond;
	logic        trQualified;
	logic        srcRead;
	logic [7:0]  stepMult;
	logic        baseTick;

	// ==========================================================
	// Field decode
	assign latchEnable  = transientConfig_ff[`TED_CFG_LATCH_BIT];       // RULE6
	assign axisEnable   =
		transientConfig_ff[`TED_CFG_EN_HI:`TED_CFG_EN_LO];          // RULE6
	assign filterBypass = transientConfig_ff[`TED_CFG_BYPASS_BIT];      // RULE6
	assign counterModeSelect =
		transientThreshold_ff[`TED_THS_MODE_BIT];                   // RULE17
	assign thresholdValue =
		transientThreshold_ff[`TED_THS_VAL_HI:`TED_THS_VAL_LO];     // RULE15
	assign srcRead = regReq.rdEn && (regReq.addr == `TED_ADDR_TR_SRC);

	// Low-noise caps the threshold at 4 g instead of 8 g
	assign effThreshold = (lowNoiseEnable &&
		thresholdValue > `TED_THS_LOWNOISE_MAX) ?
		`TED_THS_LOWNOISE_MAX : thresholdValue;                     // RULE16

	// Bypass picks raw data; the channel then acts as a motion detector
	assign selAxes = filterBypass ? rawAxes : filteredAxes;             // RULE8

	// ==========================================================
	// Per-axis magnitude compare against threshold
	generate
		for (genvar i = 0; i < 3; i++) begin : g_axis
			logic [11:0] mag;
			logic [7:0]  magUnits;
			assign mag = selAxes[i][`TED_SAMPLE_SIGN_BIT] ?
				12'(-selAxes[i]) : selAxes[i];
			// 16 sample counts per threshold count
			assign magUnits =
				mag[`TED_SAMPLE_THS_HI:`TED_SAMPLE_THS_LO];
			assign axisOver[i] = axisEnable[i] &&
				(magUnits > {1'b0, effThreshold});          // RULE7
			assign axisNeg[i] =
				selAxes[i][`TED_SAMPLE_SIGN_BIT];           // RULE11
		end
	endgenerate

	// Latest comparison held until the next sample
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			liveOver_ff <= 3'h0;
			livePol_ff  <= 3'h0;
		end else if (sampleValid) begin
			liveOver_ff <= axisOver;                             // RULE7
			livePol_ff  <= axisNeg & axisOver;                   // RULE11
		end
	end

	// ==========================================================
	// Debounce step length by data rate and oversampling mode
	always_comb begin
		case (outputDataRate)
		`TED_ODR_800: stepMult = `TED_MULT_1;
		`TED_ODR_400: stepMult = `TED_MULT_2;
		`TED_ODR_200: stepMult = (oversampleMode == TED_MODE_HIGH_RESOLUTION_MODE) ?
			`TED_MULT_2 : `TED_MULT_4;
		`TED_ODR_100: stepMult = (oversampleMode == TED_MODE_HIGH_RESOLUTION_MODE) ?
			`TED_MULT_2 : `TED_MULT_8;
		`TED_ODR_50: stepMult = (oversampleMode == TED_MODE_HIGH_RESOLUTION_MODE) ?
			`TED_MULT_2 : `TED_MULT_16;
		`TED_ODR_12P5: begin
			case (oversampleMode)
			TED_MODE_NORMAL:  stepMult = `TED_MULT_16;
			TED_MODE_HIGH_RESOLUTION_MODE: stepMult = `TED_MULT_2;
			default:          stepMult = `TED_MULT_64;
			endcase
		end
		default: begin
			// 6.25 Hz and 1.56 Hz share the long-step caps
			case (oversampleMode)
			TED_MODE_NORMAL:   stepMult = `TED_MULT_16;      // RULE5
			TED_MODE_LOWNOISE: stepMult = `TED_MULT_64;      // RULE5
			TED_MODE_HIGH_RESOLUTION_MODE:  stepMult = `TED_MULT_2;       // RULE4
			default:           stepMult = `TED_MULT_128;     // RULE5
			endcase
		end
		endcase
	end

	assign baseTick = (baseCnt_ff == BASE_STEP_CYCLES - 1);

	// Base 1.25 ms tick from the system clock
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			baseCnt_ff <= 32'h0000_0000;
		end else if (baseTick) begin
			baseCnt_ff <= 32'h0000_0000;
		end else begin
			baseCnt_ff <= baseCnt_ff + 32'h0000_0001;
		end
	end

	// Step tick every stepMult base ticks; a shorter step ends the current one at the first base tick where its count reaches the new length
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			multCnt_ff  <= 8'h00;
			stepTick_ff <= 1'b0;
		end else begin
			stepTick_ff <= 1'b0;
			if (baseTick) begin
				if (multCnt_ff + 8'h01 >= stepMult) begin
					multCnt_ff  <= 8'h00;
					stepTick_ff <= 1'b1;                 // RULE4
				end else begin
					multCnt_ff <= multCnt_ff + 8'h01;
				end
			end
		end
	end

	// ==========================================================
	// Transient debounce counter
	assign trCond = |liveOver_ff;

	always_comb begin
		nxt_trDebounce = trDebounce_ff;
		if (trCond) begin
			if (trDebounce_ff < transientCount_ff)
				nxt_trDebounce = trDebounce_ff + 8'h01;
		end else if (counterModeSelect) begin
			nxt_trDebounce = 8'h00;                              // RULE20
		end else if (trDebounce_ff != 8'h00) begin
			nxt_trDebounce = trDebounce_ff - 8'h01;              // RULE20
		end
	end

	// Event once the debounce counter reaches count while the condition holds
	assign trQualified = trCond &&
		(nxt_trDebounce >= transientCount_ff);                      // RULE18

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trDebounce_ff <= `TED_RST_BYTE;
		end else if (stepTick_ff) begin
			trDebounce_ff <= nxt_trDebounce;                     // RULE17
		end
	end

	// ==========================================================
	// Source register; a read clears first so a same-cycle event wins
	always_comb begin
		nxt_srcEvent  = srcRead ? 3'h0 : srcEvent_ff;                // RULE14
		nxt_srcPol    = srcRead ? 3'h0 : srcPol_ff;                  // RULE14
		nxt_srcActive = srcRead ? 1'b0 : srcActive_ff;               // RULE14
		if (stepTick_ff) begin
			if (nxt_srcActive && latchEnable) begin
				// Frozen until the host reads
				nxt_srcEvent = nxt_srcEvent;                 // RULE12
			end else if (trQualified) begin
				nxt_srcEvent  = nxt_srcEvent | liveOver_ff;  // RULE13
				nxt_srcPol    = (nxt_srcPol & ~liveOver_ff) |
					livePol_ff;                          // RULE13
				nxt_srcActive = 1'b1;                        // RULE10
			end else if (!nxt_srcActive) begin
				nxt_srcEvent = 3'h0;                         // RULE22
				nxt_srcPol   = 3'h0;                         // RULE22
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			srcEvent_ff  <= 3'h0;
			srcPol_ff    <= 3'h0;
			srcActive_ff <= `TED_RST_BIT;
		end else begin
			srcEvent_ff  <= nxt_srcEvent;                        // RULE19
			srcPol_ff    <= nxt_srcPol;                          // RULE11
			srcActive_ff <= nxt_srcActive;                       // RULE10
		end
	end

	// Level request held until the source read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			transientIrq_ff <= 1'b0;
		end else begin
			transientIrq_ff <= nxt_srcActive &&
				transientIrqEnable;                          // RULE21
		end
	end

	// ==========================================================
	// Freefall/motion debounce, same step timer
	always_comb begin
		nxt_ffDebounce = ffDebounce_ff;
		if (ffMotionCond) begin
			if (ffDebounce_ff < ffMotionCount_ff)
				nxt_ffDebounce = ffDebounce_ff + 8'h01;      // RULE3
			else
				nxt_ffDebounce = ffMotionCount_ff;           // RULE3
		end else if (ffMotionCounterMode) begin
			nxt_ffDebounce = 8'h00;
		end else if (ffDebounce_ff != 8'h00) begin
			nxt_ffDebounce = ffDebounce_ff - 8'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ffDebounce_ff    <= `TED_RST_BYTE;
			ffMotionEvent_ff <= 1'b0;
		end else if (stepTick_ff) begin
			ffDebounce_ff    <= nxt_ffDebounce;                  // RULE4
			ffMotionEvent_ff <= ffMotionCond &&
				(nxt_ffDebounce == ffMotionCount_ff);        // RULE2
		end
	end

	// ==========================================================
	// Register writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ffMotionCount_ff      <= `TED_RST_BYTE;              // RULE1
			transientConfig_ff    <= `TED_RST_CFG;               // RULE6
			transientThreshold_ff <= `TED_RST_BYTE;              // RULE17
			transientCount_ff     <= `TED_RST_BYTE;              // RULE18
		end else if (regReq.wrEn) begin
			case (regReq.addr)
			`TED_ADDR_FFMT_COUNT:
				ffMotionCount_ff <= regReq.wrData;           // RULE1
			`TED_ADDR_TR_CFG:
				transientConfig_ff <= regReq.wrData[
					`TED_CFG_LATCH_BIT:`TED_CFG_BYPASS_BIT]; // RULE6
			`TED_ADDR_TR_THS:
				transientThreshold_ff <= regReq.wrData;      // RULE15
			`TED_ADDR_TR_COUNT:
				transientCount_ff <= regReq.wrData;          // RULE18
			default: ;
			endcase
		end
	end

	// ==========================================================
	// Register reads, data valid the cycle after the strobe
	always_comb begin
		case (regReq.addr)
		`TED_ADDR_FFMT_COUNT: nxt_regRdData = ffMotionCount_ff;
		`TED_ADDR_TR_CFG:     nxt_regRdData = {3'h0, transientConfig_ff};
		`TED_ADDR_TR_SRC:     nxt_regRdData = {1'b0, srcActive_ff,
			srcEvent_ff[2], srcPol_ff[2], srcEvent_ff[1],
			srcPol_ff[1], srcEvent_ff[0], srcPol_ff[0]};         // RULE9
		`TED_ADDR_TR_THS:     nxt_regRdData = transientThreshold_ff;
		`TED_ADDR_TR_COUNT:   nxt_regRdData = transientCount_ff;
		default:              nxt_regRdData = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData_ff <= 8'h00;
		end else if (regReq.rdEn) begin
			regRdData_ff <= nxt_regRdData;
		end
	end

	// ==========================================================
	// Outputs straight from flops
	assign regRdData     = regRdData_ff;
	assign transientIrq  = transientIrq_ff;
	assign ffMotionEvent = ffMotionEvent_ff;
	assign stepTick      = stepTick_ff;

endmodule

/* File: testbench/ted_properties.sv */
/*
 Port checker for the transient event detector.
 Assumes it is bound into transient_event_detector by the bench top.
*/
`timescale 1ns/1ps
`include "ted_cfg.svh"

module ted_properties #(
	parameter int unsigned BASE_STEP_CYCLES = 10
) (
	input wire logic                  sys_clk,
	input wire logic                  rst_n,
	input wire ted_pkg::ted_reg_req_s regReq,
	input wire logic [7:0]            regRdData,
	input wire logic [2:0]            outputDataRate,
	input wire ted_pkg::ted_mode_e    oversampleMode,
	input wire logic                  transientIrqEnable,
	input wire logic                  ffMotionCond,
	input wire logic                  transientIrq,
	input wire logic                  ffMotionEvent,
	input wire logic                  stepTick
);
	import ted_pkg::*;

	logic [31:0] gap_ff;
	logic        armed_ff;
	logic [2:0]  rate_ff;
	ted_mode_e   mode_ff;

	// ==========================================================
	// Step length in base steps for a rate and oversampling mode
	function automatic int unsigned stepMult(input logic [2:0] r,
		input ted_mode_e m);
		if (m == TED_MODE_HIGH_RESOLUTION_MODE)
			return (r == `TED_ODR_800) ? `TED_MULT_1 : `TED_MULT_2;
		if (r <= `TED_ODR_50)
			return `TED_MULT_1 << r;
		if (m == TED_MODE_NORMAL)
			return `TED_MULT_16;
		if (m == TED_MODE_LOWNOISE || r == `TED_ODR_12P5)
			return `TED_MULT_64;
		return `TED_MULT_128;
	endfunction

	// Gap since last tick; a rate change disarms, as that step may be cut
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_ff   <= 32'h0000_0000;
			armed_ff <= 1'b0;
			rate_ff  <= 3'h0;
			mode_ff  <= TED_MODE_NORMAL;
		end else begin
			gap_ff   <= stepTick ? 32'h0000_0001 : gap_ff + 32'h0000_0001;
			rate_ff  <= outputDataRate;
			mode_ff  <= oversampleMode;
			armed_ff <= (stepTick || armed_ff) &&
				outputDataRate == rate_ff && oversampleMode == mode_ff;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_src_read;
		regReq.rdEn && regReq.addr == `TED_ADDR_TR_SRC;
	endsequence

	sequence s_cfg_read;
		regReq.rdEn && regReq.addr == `TED_ADDR_TR_CFG;
	endsequence

	// ==========================================================
	// Properties
	a_src_read_clears: assert property
		(s_src_read ##0 !stepTick |=> !transientIrq)
		else $error("irq still high after source read");
	a_src_top_zero: assert property
		(s_src_read |=> !regRdData[7])
		else $error("source bit 7 not zero");
	a_cfg_upper_zero: assert property
		(s_cfg_read |=> regRdData[7:5] == 3'h0)
		else $error("config upper bits not zero");
	a_irq_gated: assert property
		(!transientIrqEnable |=> !transientIrq)
		else $error("irq high while disabled");
	a_irq_level_hold: assert property
		(transientIrq && transientIrqEnable && !regReq.rdEn |=> transientIrq)
		else $error("irq dropped without a read");
	a_irq_rise_step: assert property
		($rose(transientIrq) && $past(transientIrqEnable, 2)
			|-> $past(stepTick))
		else $error("irq rose without a step");
	a_tick_single: assert property
		(stepTick |=> !stepTick [*8])
		else $error("step ticks too close");
	a_tick_period: assert property
		(stepTick && armed_ff |-> gap_ff ==
			BASE_STEP_CYCLES * stepMult(outputDataRate, oversampleMode))
		else $error("step period wrong");
	a_ffm_on_step: assert property
		(!$stable(ffMotionEvent) |-> $past(stepTick))
		else $error("motion event moved off a step");
	a_ffm_needs_cond: assert property
		(stepTick && !ffMotionCond |=> !ffMotionEvent)
		else $error("motion event without condition");
endmodule

/* File: testbench/ted_host_model.sv */
/*
 Host side of the register interface: byte read and write tasks.
 Assumes the bench calls the tasks; requests are driven at falling edges.
*/
`timescale 1ns/1ps

module ted_host_model (
	input  wire logic             sys_clk,
	input  wire logic [7:0]       regRdData,
	output ted_pkg::ted_reg_req_s regReq
);
	import ted_pkg::*;

	// Idle request at time zero
	initial regReq = '0;

	// Released fields show inverted values so stale data cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		regReq = '{addr: a, wrEn: 1'b1, rdEn: 1'b0, wrData: d};
		@(negedge sys_clk);
		regReq = '{addr: ~a, wrEn: 1'b0, rdEn: 1'b0, wrData: ~d};
	endtask

	// Read data is taken one cycle after the strobe, at the next falling edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		regReq = '{addr: a, wrEn: 1'b0, rdEn: 1'b1, wrData: ~regReq.wrData};
		@(negedge sys_clk);
		d = regRdData;
		regReq = '{addr: ~a, wrEn: 1'b0, rdEn: 1'b0, wrData: regReq.wrData};
	endtask
endmodule

/* File: testbench/test_transient_event_detector.sv */
/*
 Self-checking bench for the transient event detector.
 Assumes ted_host_model drives the register port; short base step of 10.
*/
`timescale 1ns/1ps
`include "ted_cfg.svh"

module test_transient_event_detector;
	import ted_pkg::*;

	logic         sys_clk, rst_n, sampleValid, lowNoiseEnable;
	logic         transientIrqEnable, ffMotionCond, ffMotionCounterMode;
	logic         transientIrq, ffMotionEvent, stepTick;
	ted_reg_req_s regReq;
	logic [7:0]   regRdData, rdVal;
	ted_axes_s    rawAxes, filteredAxes;
	logic [2:0]   outputDataRate;
	ted_mode_e    oversampleMode;
	int           miscompares, checksDone;
	logic [7:0]   regA [4] = '{8'h18, 8'h1d, 8'h1f, 8'h20};
	logic [7:0]   regW [4] = '{8'ha5, 8'hff, 8'h9c, 8'h5a};
	logic [7:0]   regE [4] = '{8'ha5, 8'h1f, 8'h9c, 8'h5a};
	localparam int unsigned STEP_CYC = 10;
	time          stepT0;
	logic [15:0]  stepLen, stepExp;
	// Base steps per debounce step; rows normal, LOW_NOISE_LOW_POWER_MODE, high-res, LP
	logic [7:0]   stepE [4][8] = '{
		'{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h10, 8'h10, 8'h10},
		'{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h40, 8'h40},
		'{8'h01, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02},
		'{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80, 8'h80}};

	transient_event_detector #(.BASE_STEP_CYCLES(STEP_CYC))
	transient_event_detector_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
		.regRdData(regRdData), .sampleValid(sampleValid),
		.rawAxes(rawAxes), .filteredAxes(filteredAxes),
		.outputDataRate(outputDataRate), .oversampleMode(oversampleMode),
		.lowNoiseEnable(lowNoiseEnable),
		.transientIrqEnable(transientIrqEnable),
		.ffMotionCond(ffMotionCond),
		.ffMotionCounterMode(ffMotionCounterMode),
		.transientIrq(transientIrq), .ffMotionEvent(ffMotionEvent),
		.stepTick(stepTick)
	);

	ted_host_model ted_host_model_inst (
		.sys_clk(sys_clk), .regRdData(regRdData), .regReq(regReq)
	);

	// ==========================================================
	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// Helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checksDone++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			miscompares++;
		end
	endtask

	task results;
		if (miscompares == 0 && checksDone > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Waits for n steps, then lets the step edge's updates land
	task automatic ticks(input int n);
		int c = 0;
		int k = 0;
		while (c < n && k < 4000 * n) begin
			@(negedge sys_clk);
			k++;
			if (stepTick === 1'b1)
				c++;
		end
		if (c < n) begin
			miscompares++;
			results();
		end
		@(negedge sys_clk);
	endtask

	// Y axis always large but never enabled
	task automatic smp(input logic [11:0] x, input logic [11:0] z,
		input logic raw);
		ted_axes_s ax;
		@(negedge sys_clk);
		ax = '{z: z, y: 12'h190, x: x};
		rawAxes = raw ? ax : '0;
		filteredAxes = raw ? '0 : ax;
		sampleValid = 1'b1;
		@(negedge sys_clk);
		sampleValid = 1'b0;
	endtask

	task automatic srcIs(input logic [7:0] exp);
		ted_host_model_inst.rd(`TED_ADDR_TR_SRC, rdVal);
		check(rdVal, exp);
	endtask

	// Flush any held event, then expect a quiet source
	task automatic settle();
		ticks(2);
		ted_host_model_inst.rd(`TED_ADDR_TR_SRC, rdVal);
		ticks(2);
	endtask

	// X negative, then X positive with Z added, then quiet
	task automatic latchRun(input logic [7:0] cfg, input logic [7:0] exp);
		ted_host_model_inst.wr(`TED_ADDR_TR_CFG, cfg);
		smp(12'hed4, 12'h000, 1'b0);
		ticks(2);
		check({7'h00, transientIrq}, 8'h01);
		smp(12'h12c, 12'h190, 1'b0);
		ticks(2);
		smp(12'h000, 12'h000, 1'b0);
		ticks(2);
		srcIs(exp);
		check({7'h00, transientIrq}, 8'h00);
		ticks(1);
		srcIs(8'h00);
	endtask

	// Three hits, one miss, three hits against a count of four
	task automatic deb(input logic mode, input logic [7:0] exp);
		ted_host_model_inst.wr(`TED_ADDR_TR_THS, {mode, 7'h10});
		ted_host_model_inst.wr(`TED_ADDR_TR_COUNT, 8'h04);
		smp(12'h000, 12'h000, 1'b0);
		ticks(2);
		smp(12'h12c, 12'h000, 1'b0);
		ticks(3);
		smp(12'h000, 12'h000, 1'b0);
		ticks(1);
		smp(12'h12c, 12'h000, 1'b0);
		ticks(3);
		smp(12'h000, 12'h000, 1'b0);
		ticks(1);
		srcIs(exp);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		sampleValid = 1'b0;
		rawAxes = '0;
		filteredAxes = '0;
		outputDataRate = `TED_ODR_800;
		oversampleMode = TED_MODE_NORMAL;
		lowNoiseEnable = 1'b0;
		transientIrqEnable = 1'b1;
		ffMotionCond = 1'b0;
		ffMotionCounterMode = 1'b0;
		miscompares = 0;
		checksDone = 0;
		repeat (3) @(negedge sys_clk);
		rst_n = 1'b1;
		for (int i = 0; i < 4; i++) begin
			ted_host_model_inst.rd(regA[i], rdVal);
			check(rdVal, 8'h00);
		end
		srcIs(8'h00);
		ted_host_model_inst.rd(8'h21, rdVal);
		check(rdVal, 8'h00);
		for (int i = 0; i < 4; i++)
			ted_host_model_inst.wr(regA[i], regW[i]);
		ted_host_model_inst.wr(`TED_ADDR_TR_SRC, 8'hff);
		for (int i = 0; i < 4; i++) begin
			ted_host_model_inst.rd(regA[i], rdVal);
			check(rdVal, regE[i]);
		end
		srcIs(8'h00);
		ted_host_model_inst.wr(`TED_ADDR_TR_THS, 8'h10);
		ted_host_model_inst.wr(`TED_ADDR_TR_COUNT, 8'h00);
		latchRun(8'h0a, 8'h62);
		latchRun(8'h1a, 8'h43);
		// Unfiltered path with the interrupt gated off, then raw data ignored with bypass off
		transientIrqEnable = 1'b0;
		ted_host_model_inst.wr(`TED_ADDR_TR_CFG, 8'h03);
		smp(12'h12c, 12'h000, 1'b1);
		ticks(2);
		check({7'h00, transientIrq}, 8'h00);
		srcIs(8'h42);
		transientIrqEnable = 1'b1;
		ted_host_model_inst.wr(`TED_ADDR_TR_CFG, 8'h02);
		smp(12'h12c, 12'h000, 1'b1);
		settle();
		srcIs(8'h00);
		// Full-scale threshold, capped and uncapped, then debounce in both counter modes
		ted_host_model_inst.wr(`TED_ADDR_TR_THS, 8'h7f);
		lowNoiseEnable = 1'b1;
		smp(12'h44c, 12'h000, 1'b0);
		ticks(2);
		srcIs(8'h42);
		lowNoiseEnable = 1'b0;
		smp(12'h44c, 12'h000, 1'b0);
		settle();
		srcIs(8'h00);
		deb(1'b1, 8'h00);
		deb(1'b0, 8'h42);
		// Motion debounce at the longest low-power step
		outputDataRate = 3'h6;
		oversampleMode = TED_MODE_LOWPOWER;
		ted_host_model_inst.wr(`TED_ADDR_FFMT_COUNT, 8'h02);
		ffMotionCounterMode = 1'b1;
		ffMotionCond = 1'b1;
		ticks(1);
		check({7'h00, ffMotionEvent}, 8'h00);
		ticks(3);
		check({7'h00, ffMotionEvent}, 8'h01);
		ffMotionCond = 1'b0;
		ticks(1);
		check({7'h00, ffMotionEvent}, 8'h00);
		// Step length for every rate and mode; first step may be cut
		for (int m = 0; m < 4; m++) begin
			for (int r = 0; r < 8; r++) begin
				outputDataRate = 3'(r);
				oversampleMode = ted_mode_e'(m);
				ticks(1);
				stepT0 = $time;
				ticks(1);
				stepLen = 16'(($time - stepT0) / `TED_CLK_PERIOD_NS);
				stepExp = 16'(STEP_CYC * stepE[m][r]);
				check(stepLen[15:8], stepExp[15:8]);
				check(stepLen[7:0], stepExp[7:0]);
			end
		end
		results();
	end
endmodule

bind transient_event_detector ted_properties #(
	.BASE_STEP_CYCLES(BASE_STEP_CYCLES)
) ted_properties_inst (
	.sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
	.regRdData(regRdData), .outputDataRate(outputDataRate),
	.oversampleMode(oversampleMode),
	.transientIrqEnable(transientIrqEnable), .ffMotionCond(ffMotionCond),
	.transientIrq(transientIrq), .ffMotionEvent(ffMotionEvent),
	.stepTick(stepTick)
);
